// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`include "timer_output_cfg.svh"
module tb_top;
  import timer_output_pkg::*;
  // Stimulus and observed signals
  logic        clk_i, rst_i, run, clr, lo, hi;
  logic [3:0]  sel;
  logic [15:0] ca, cb, count_o;
  logic [1:0]  en, alv, os;
  logic        match_a_o, match_b_o, pin0, pin1;
  out_mode_type mode_0_o, mode_1_o;
  int          mismatches, samples_checked, n;
  typedef struct {
    logic [1:0] en, alv, os, mode;
    logic clr;
    out_mode_type m0, m1;
  } row_type;
  row_type rows[12];

  timer_output_waveform_control uut (
    .clk_i(clk_i), .rst_i(rst_i), .count_run_bit_i(run), .prescale_sel_i(sel),
    .compare_reg_a_i(ca), .compare_reg_b_i(cb), .output_enable_bit_i(en),
    .active_level_select_i(alv), .one_shot_select_i(os), .compare_mode_field_lo_i(lo),
    .compare_mode_field_hi_i(hi), .clear_on_compare_reg_b_match_i(clr), .mode_0_o(mode_0_o),
    .mode_1_o(mode_1_o), .count_o(count_o), .match_a_o(match_a_o), .match_b_o(match_b_o),
    .timer_output_pin_0_o(pin0), .timer_output_pin_1_o(pin1));

  // 50 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Stop, load a setup, then start counting from zero
  task cfg(input logic [1:0] e, a, m, input logic c, input logic [15:0] ra, rb);
    @(negedge clk_i);
    run = 1'b0; en = e; alv = a; {hi, lo} = m; clr = c; ca = ra; cb = rb;
    @(negedge clk_i);
    run = 1'b1;
  endtask : cfg

  // Bounded wait; a miss shows up as a failed compare
  task wait_cnt(input logic [15:0] v);
    n = 0;
    while (count_o !== v && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check("count reached", count_o, v);
  endtask : wait_cnt

  task run_len(input logic p, input logic v);
    n = 0;
    while (((p ? pin1 : pin0) === v) && n < 200) begin
      @(negedge clk_i);
      n++;
    end
  endtask : run_len

  // Hang guard, far above the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end

  // Decode table, sampled while stopped so pins sit at the stop level
  initial begin
    rows[0]  = '{2'b00, 2'b00, 2'b00, `MODE_TOGGLE, 1'b0, OUT_FIXED, OUT_FIXED};
    rows[1]  = '{2'b00, 2'b11, 2'b00, `MODE_PWM_LO, 1'b0, OUT_FIXED, OUT_FIXED};
    rows[2]  = '{2'b01, 2'b01, 2'b00, `MODE_TOGGLE, 1'b0, OUT_TOGGLE, OUT_FIXED};
    rows[3]  = '{2'b01, 2'b00, 2'b00, `MODE_PWM_LO, 1'b0, OUT_PWM, OUT_FIXED};
    rows[4]  = '{2'b01, 2'b11, 2'b00, `MODE_PWM_HI, 1'b0, OUT_PWM, OUT_FIXED};
    rows[5]  = '{2'b01, 2'b00, 2'b00, `MODE_PERIOD, 1'b1, OUT_PPG, OUT_FIXED};
    rows[6]  = '{2'b10, 2'b10, 2'b00, `MODE_TOGGLE, 1'b0, OUT_FIXED, OUT_TOGGLE};
    rows[7]  = '{2'b10, 2'b00, 2'b00, `MODE_PWM_HI, 1'b0, OUT_FIXED, OUT_PWM};
    rows[8]  = '{2'b10, 2'b10, 2'b00, `MODE_PERIOD, 1'b1, OUT_FIXED, OUT_TOGGLE};
    rows[9]  = '{2'b11, 2'b01, 2'b00, `MODE_PWM_LO, 1'b0, OUT_PWM, OUT_TOGGLE};
    rows[10] = '{2'b11, 2'b00, 2'b01, `MODE_PWM_HI, 1'b0, OUT_ONE_SHOT, OUT_PWM};
    rows[11] = '{2'b11, 2'b11, 2'b10, `MODE_PERIOD, 1'b1, OUT_PPG, OUT_ONE_SHOT};
    rst_i = 1'b1; run = 1'b0; sel = 4'h0; ca = 16'h0000; cb = 16'h0000;
    en = 2'b00; alv = 2'b00; os = 2'b00; lo = 1'b0; hi = 1'b0; clr = 1'b0;
    mismatches = 0; samples_checked = 0;
    repeat (8) @(negedge clk_i);
    check("pin 0 in reset", pin0, 1'b1);
    check("count in reset", count_o, 16'h0000);
    rst_i = 1'b0;
    foreach (rows[i]) begin
      @(negedge clk_i);
      en = rows[i].en; alv = rows[i].alv; os = rows[i].os; {hi, lo} = rows[i].mode; clr = rows[i].clr;
      @(negedge clk_i);
      check("mode 0", mode_0_o, rows[i].m0);
      check("mode 1", mode_1_o, rows[i].m1);
      if (!rows[i].os[0]) check("pin 0 level", pin0, !rows[i].alv[0]);
      if (!rows[i].os[1]) check("pin 1 level", pin1, !rows[i].alv[1]);
    end
    os = 2'b00;
    // Disabled pins stay fixed while the counter runs
    cfg(2'b00, 2'b00, `MODE_PWM_LO, 1'b0, 16'h0002, 16'h0002);
    wait_cnt(16'h0006);
    check("fixed pin 0", pin0, 1'b1);
    check("fixed pin 1", pin1, 1'b1);
    // Count clock spacing for codes 0 to 8 and 15; codes above eight clamp
    for (int s = 0; s < 10; s++) begin
      sel = (s == 9) ? 4'hf : s[3:0];
      cfg(2'b01, 2'b00, `MODE_PWM_LO, 1'b0, 16'hffff, 16'hffff);
      wait_cnt(16'h0001);
      n = 0;
      while (count_o === 16'h0001 && n < 2000) begin
        @(negedge clk_i);
        n++;
      end
      check("count step cycles", n, 4 << ((s > 8) ? 8 : s));
    end
    sel = 4'h0;
    // Width ends one cycle after the compare value is reached
    cfg(2'b01, 2'b00, `MODE_PWM_LO, 1'b0, 16'h0002, 16'hffff);
    wait_cnt(16'h0002);
    check("pwm active", pin0, 1'b1);
    check("match a pulse", match_a_o, 1'b1);
    @(negedge clk_i);
    check("pwm inactive", pin0, 1'b0);
    check("match a ended", match_a_o, 1'b0);
    cfg(2'b10, 2'b10, `MODE_PWM_HI, 1'b0, 16'hffff, 16'h0003);
    wait_cnt(16'h0003);
    check("pwm1 active", pin1, 1'b0);
    check("match b pulse", match_b_o, 1'b1);
    @(negedge clk_i);
    check("pwm1 inactive", pin1, 1'b1);
    run = 1'b0;
    @(negedge clk_i);
    check("pwm1 stop", pin1, 1'b0);
    // Compare moved below the counter keeps the pin active
    cfg(2'b01, 2'b00, `MODE_PWM_HI, 1'b0, 16'h0064, 16'hffff);
    wait_cnt(16'h0014);
    ca = 16'h0005;
    wait_cnt(16'h006e);
    check("full duty", pin0, 1'b1);
    // Second match in one period is ignored, then stop
    cfg(2'b01, 2'b00, `MODE_PWM_LO, 1'b0, 16'h0004, 16'hffff);
    wait_cnt(16'h0005);
    check("after width", pin0, 1'b0);
    ca = 16'h001e;
    wait_cnt(16'h0023);
    check("second match", pin0, 1'b0);
    run = 1'b0;
    @(negedge clk_i);
    check("pwm stop", pin0, 1'b1);
    // Toggle on both pins, then stop to inactive
    cfg(2'b11, 2'b00, `MODE_TOGGLE, 1'b0, 16'h0003, 16'h0005);
    wait_cnt(16'h0003);
    check("toggle before", pin0, 1'b1);
    @(negedge clk_i);
    check("toggle pin 0", pin0, 1'b0);
    check("toggle pin 1 idle", pin1, 1'b1);
    wait_cnt(16'h0005);
    check("toggle match b", match_b_o, 1'b1);
    @(negedge clk_i);
    check("toggle pin 1", pin1, 1'b0);
    run = 1'b0;
    @(negedge clk_i);
    check("toggle stop 0", pin0, 1'b1);
    check("toggle stop 1", pin1, 1'b1);
    // Active low period pulse: width 3 counts, period 8 counts
    cfg(2'b01, 2'b01, `MODE_PERIOD, 1'b1, 16'h0003, 16'h0007);
    run_len(1'b0, 1'b0);
    run_len(1'b0, 1'b1);
    run_len(1'b0, 1'b0);
    check("ppg width", n, 12);
    run_len(1'b0, 1'b1);
    check("ppg rest", n, 20);
    check("count cleared", count_o <= 16'h0007, 1'b1);
    // Reset in mid-run; the period pulse restarts active two edges later
    @(negedge clk_i);
    rst_i = 1'b1;
    @(negedge clk_i);
    check("pin 0 mid reset", pin0, 1'b1);
    check("count mid reset", count_o, 16'h0000);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("pin 0 after reset", pin0, 1'b0);
    end_of_test();
  end
endmodule : tb_top

// ==== verilog/count_clock_divider.sv ====
`timescale 1ns/1ps
`include "timer_output_cfg.svh"
module count_clock_divider (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      run_i,
  input  wire logic [`PRE_SEL_WIDTH-1:0] prescale_sel_i,
  output logic                           tick_o
);
  // Last prescaler state for a select code; codes above eight clamp to eight, last state 1023
  function automatic logic [`PRE_WIDTH-1:0] limit_of(input logic [`PRE_SEL_WIDTH-1:0] sel);
    logic [`PRE_SEL_WIDTH-1:0] s;
    s = (sel > `PRE_SEL_MAX) ? `PRE_SEL_MAX : sel;
    limit_of = 10'((`PRE_BASE_DIV << s) - `PRE_ONE);
  endfunction : limit_of

  logic [`PRE_WIDTH-1:0] pre_q;
  wire                   pre_end = (pre_q == limit_of(prescale_sel_i));

  // Restart from zero while stopped so the first count clock is a full one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q  <= `PRE_ZERO;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      pre_q  <= `PRE_ZERO;
      tick_o <= 1'b0;
    end else begin
      pre_q  <= pre_end ? `PRE_ZERO : pre_q + `PRE_STEP; // [R9]
      tick_o <= pre_end;
    end
  end

  tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i) tick_o |=> !tick_o [*3]) // [R9]
    else $error("count clock ticks closer than four cycles");
endmodule : count_clock_divider

// ==== verilog/timer_output_cfg.svh ====
`ifndef TIMER_OUTPUT_CFG_SVH
`define TIMER_OUTPUT_CFG_SVH
// Counter geometry
`define CNT_WIDTH       16
`define CNT_ZERO        16'h0000
`define CNT_ONE         16'h0001
// Count clock prescaler: divide by 4 shifted left by the select code
`define PRE_WIDTH       10
`define PRE_SEL_WIDTH   4
`define PRE_SEL_MAX     4'h8
`define PRE_BASE_DIV    11'h004
`define PRE_ONE         11'h001
`define PRE_ZERO        10'h000
`define PRE_STEP        10'h001
// Compare mode field codes {hi, lo}
`define MODE_TOGGLE     2'b00
`define MODE_PWM_LO     2'b01
`define MODE_PWM_HI     2'b10
`define MODE_PERIOD     2'b11
// Pin level after reset
`define PIN_RESET       1'b1
`endif

// ==== verilog/timer_output_pkg.sv ====
package timer_output_pkg;
  // Waveform chosen for one output channel
  typedef enum logic [2:0] {
    OUT_FIXED,
    OUT_TOGGLE,
    OUT_PWM,
    OUT_PPG,
    OUT_ONE_SHOT
  } out_mode_type;
endpackage : timer_output_pkg

// ==== verilog/timer_output_waveform_control.sv ====
// Summary of operation
// [R1] Enabled channel follows the selected waveform mode
// [R2] Disabled channel holds inverse of level select
// [R3] Software uses only the listed bit combinations
// [R4] Mode bits choose toggle, PWM or PROGRAMMABLE_PERIOD_PULSE
// [R5] Toggle mode inverts pin on each compare match
// [R6] Toggle stop drives pin to inactive level
// [R7] PWM period is full wrap, width compare
// [R8] Software keeps clear bit low in PWM
// [R9] Count clock is system clock over 4..1024
// [R10] Software never loads zero into PWM compare
// [R11] PWM pin changes once per period at most
// [R12] Compare below counter gives full-duty period
// [R13] Software rewrites compare from its match interrupt
// [R14] PWM stop drives pin to active level
// [R15] PROGRAMMABLE_PERIOD_PULSE on pin 0, period compare B plus one
// [R16] PROGRAMMABLE_PERIOD_PULSE width is compare A count clocks
// [R17] Software sets clear bit high in PROGRAMMABLE_PERIOD_PULSE
// [R18] Period start active, width match inactive
`timescale 1ns/1ps
`include "timer_output_cfg.svh"
module timer_output_waveform_control (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      count_run_bit_i,
  input  wire logic [`PRE_SEL_WIDTH-1:0] prescale_sel_i,
  input  wire logic [`CNT_WIDTH-1:0]     compare_reg_a_i,
  input  wire logic [`CNT_WIDTH-1:0]     compare_reg_b_i,
  input  wire logic [1:0]                output_enable_bit_i,
  input  wire logic [1:0]                active_level_select_i,
  input  wire logic [1:0]                one_shot_select_i,
  input  wire logic                      compare_mode_field_lo_i,
  input  wire logic                      compare_mode_field_hi_i,
  input  wire logic                      clear_on_compare_reg_b_match_i,
  output timer_output_pkg::out_mode_type mode_0_o,
  output timer_output_pkg::out_mode_type mode_1_o,
  output logic [`CNT_WIDTH-1:0]          count_o,
  output logic                           match_a_o,
  output logic                           match_b_o,
  output logic                           timer_output_pin_0_o,
  output logic                           timer_output_pin_1_o
);
  import timer_output_pkg::*;

  // Channel mode from channel index, enable, one-shot select and mode field.
  // Combinations outside the allowed set fall onto the nearest listed mode;
  // keeping to the allowed set is left to software.
  function automatic out_mode_type decode_mode(input logic       ch1,
                                               input logic       en,
                                               input logic       os,
                                               input logic [1:0] mode);
    out_mode_type m;
    m = OUT_FIXED;
    if (!en) begin
      m = OUT_FIXED; // [R2]
    end else if (os) begin
      m = OUT_ONE_SHOT;
    end else if (!ch1) begin
      case (mode) // [R4] [R3] [R8] [R17]
        `MODE_TOGGLE: m = OUT_TOGGLE;
        `MODE_PWM_LO: m = OUT_PWM;
        `MODE_PWM_HI: m = OUT_PWM;
        `MODE_PERIOD: m = OUT_PPG;
        default:      m = OUT_FIXED;
      endcase
    end else begin
      // Output 1 has no PROGRAMMABLE_PERIOD_PULSE; its compare B only toggles there
      m = (mode == `MODE_PWM_HI) ? OUT_PWM : OUT_TOGGLE; // [R15]
    end
    decode_mode = m;
  endfunction : decode_mode

  wire       tick;
  wire       period_start;
  wire [1:0] mode_field = {compare_mode_field_hi_i, compare_mode_field_lo_i};
  wire [1:0] match_w    = {match_b_o, match_a_o};

  // Count clock enable from the system clock
  count_clock_divider u_divider (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .run_i          (count_run_bit_i),
    .prescale_sel_i (prescale_sel_i),
    .tick_o         (tick)
  );

  // Counter with compare matches and period start pulses
  up_counter u_counter (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .run_i                 (count_run_bit_i),
    .tick_i                (tick),
    .clear_on_compare_reg_b_match_i (clear_on_compare_reg_b_match_i),
    .compare_reg_a_i       (compare_reg_a_i),
    .compare_reg_b_i       (compare_reg_b_i),
    .count_o               (count_o),
    .match_a_o             (match_a_o),
    .match_b_o             (match_b_o),
    .period_start_o        (period_start)
  );

  // One level register per output pin.
  // Pin level conventions: the inactive toggle level and the active PWM/PROGRAMMABLE_PERIOD_PULSE
  // level are both the inverse of the level select, so a stopped counter and
  // a disabled output give the same pin level in pulse modes.
  for (genvar g = 0; g < 2; g++) begin : chan
    out_mode_type mode;
    logic         lvl_q;
    logic         lvl_d;
    logic         done_q;
    logic         done_d;
    wire          alv    = active_level_select_i[g];
    wire          hit    = match_w[g];
    wire          pulse  = (mode == OUT_PWM) || (mode == OUT_PPG);

    assign mode = decode_mode(g == 1, output_enable_bit_i[g], one_shot_select_i[g], mode_field);

    // Next pin level per mode
    always_comb begin
      lvl_d  = lvl_q;
      done_d = done_q;
      case (mode)
        OUT_FIXED: begin
          lvl_d  = !alv; // [R2]
          done_d = 1'b0;
        end
        OUT_ONE_SHOT: begin
          // Pin is steered by the one-shot logic; hold it here
          lvl_d  = lvl_q;
          done_d = 1'b0;
        end
        OUT_TOGGLE: begin
          done_d = 1'b0;
          if (!count_run_bit_i) begin
            lvl_d = !alv; // [R6]
          end else if (hit) begin
            lvl_d = !lvl_q; // [R5] [R1]
          end
        end
        OUT_PWM, OUT_PPG: begin
          if (!count_run_bit_i) begin
            lvl_d  = !alv; // [R14]
            done_d = 1'b0;
          end else if (period_start) begin
            lvl_d  = !alv; // [R18] [R7] [R15]
            done_d = 1'b0;
          end else if (hit && !done_q) begin
            // Only the first match counts; a rewrite below the count means
            // no match this period, so the pin stays active all through
            lvl_d  = alv; // [R11] [R12] [R16] [R7]
            done_d = 1'b1;
          end
        end
        default: begin
          lvl_d  = !alv;
          done_d = 1'b0;
        end
      endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        lvl_q  <= `PIN_RESET;
        done_q <= 1'b0;
      end else begin
        lvl_q  <= lvl_d;
        done_q <= done_d;
      end
    end
  end

  assign mode_0_o             = chan[0].mode;
  assign mode_1_o             = chan[1].mode;
  assign timer_output_pin_0_o = chan[0].lvl_q;
  assign timer_output_pin_1_o = chan[1].lvl_q;

  // Checks on the pin behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  disabled_level_a: assert property ( // [R2]
    !output_enable_bit_i[0] |=> timer_output_pin_0_o == !$past(active_level_select_i[0]))
    else $error("disabled output 0 not at inverse level");

  toggle_invert_a: assert property ( // [R5]
    chan[1].mode == OUT_TOGGLE && count_run_bit_i && match_b_o
    |=> timer_output_pin_1_o != $past(timer_output_pin_1_o))
    else $error("toggle output 1 did not invert on match");

  toggle_hold_a: assert property ( // [R1]
    chan[0].mode == OUT_TOGGLE && count_run_bit_i && !match_a_o
    |=> $stable(timer_output_pin_0_o))
    else $error("toggle output 0 changed without a match");

  toggle_stop_a: assert property ( // [R6]
    chan[0].mode == OUT_TOGGLE && !count_run_bit_i
    |=> timer_output_pin_0_o == !$past(active_level_select_i[0]))
    else $error("stopped toggle output not inactive");

  pwm_stop_a: assert property ( // [R14]
    chan[1].mode == OUT_PWM && $fell(count_run_bit_i)
    |=> timer_output_pin_1_o == !$past(active_level_select_i[1]))
    else $error("stopped PWM output not active");

  period_start_a: assert property ( // [R18]
    chan[0].pulse && count_run_bit_i && period_start
    |=> timer_output_pin_0_o == !$past(active_level_select_i[0]))
    else $error("pulse output not active at period start");

  width_match_a: assert property ( // [R16]
    chan[0].pulse && count_run_bit_i && !period_start && match_a_o && !chan[0].done_q
    |=> timer_output_pin_0_o == $past(active_level_select_i[0]) && chan[0].done_q)
    else $error("pulse output not inactive at width match");

  single_change_a: assert property ( // [R11]
    chan[0].pulse && count_run_bit_i && !period_start && chan[0].done_q
    && $stable(active_level_select_i[0]) |=> $stable(timer_output_pin_0_o))
    else $error("pulse output changed twice in one period");

  full_duty_a: assert property ( // [R12]
    chan[1].mode == OUT_PWM && count_run_bit_i && !match_b_o && !period_start
    && !chan[1].done_q && $stable(active_level_select_i[1]) |=> $stable(timer_output_pin_1_o))
    else $error("PWM output left active level without a match");

  ppg_only_pin0_a: assert property ( // [R15]
    output_enable_bit_i[1] && !one_shot_select_i[1] && mode_field == `MODE_PERIOD
    |-> mode_1_o == OUT_TOGGLE && mode_1_o != OUT_PPG)
    else $error("output 1 entered PROGRAMMABLE_PERIOD_PULSE mode");

  // Mirrored checks on the other channel, and stop-level checks
  disabled_level_1_a: assert property ( // [R2]
    !output_enable_bit_i[1] |=> timer_output_pin_1_o == !$past(active_level_select_i[1]))
    else $error("disabled output 1 not at inverse level");

  toggle_invert_0_a: assert property ( // [R5]
    chan[0].mode == OUT_TOGGLE && count_run_bit_i && match_a_o
    |=> timer_output_pin_0_o != $past(timer_output_pin_0_o))
    else $error("toggle output 0 did not invert on match");

  toggle_hold_1_a: assert property ( // [R1]
    chan[1].mode == OUT_TOGGLE && count_run_bit_i && !match_b_o
    |=> $stable(timer_output_pin_1_o))
    else $error("toggle output 1 changed without a match");

  toggle_stop_1_a: assert property ( // [R6]
    chan[1].mode == OUT_TOGGLE && !count_run_bit_i
    |=> timer_output_pin_1_o == !$past(active_level_select_i[1]))
    else $error("stopped toggle output 1 not inactive");

  // PROGRAMMABLE_PERIOD_PULSE stops at the active level just as PWM does
  pulse_stop_0_a: assert property ( // [R14]
    chan[0].pulse && !count_run_bit_i
    |=> timer_output_pin_0_o == !$past(active_level_select_i[0]))
    else $error("stopped pulse output 0 not active");

  period_start_1_a: assert property ( // [R18]
    chan[1].mode == OUT_PWM && count_run_bit_i && period_start
    |=> timer_output_pin_1_o == !$past(active_level_select_i[1]))
    else $error("PWM output 1 not active at period start");

  width_match_1_a: assert property ( // [R7]
    chan[1].mode == OUT_PWM && count_run_bit_i && !period_start && match_b_o && !chan[1].done_q
    |=> timer_output_pin_1_o == $past(active_level_select_i[1]) && chan[1].done_q)
    else $error("PWM output 1 not inactive at width match");

  single_change_1_a: assert property ( // [R11]
    chan[1].pulse && count_run_bit_i && !period_start && chan[1].done_q
    |=> $stable(timer_output_pin_1_o))
    else $error("PWM output 1 changed twice in one period");

  // Re-arm each period, or the next width match would be lost
  period_rearm_a: assert property ( // [R11]
    chan[0].pulse && period_start |=> !chan[0].done_q)
    else $error("width match not re-armed at period start");

  // One-shot timing lives elsewhere; this logic must not move the pin
  one_shot_hold_a: assert property ( // [R1]
    chan[0].mode == OUT_ONE_SHOT |=> $stable(timer_output_pin_0_o))
    else $error("one-shot output 0 moved by this logic");

  // Mode code 11 means PROGRAMMABLE_PERIOD_PULSE on output 0 whatever the clear bit
  ppg_decode_a: assert property ( // [R4]
    output_enable_bit_i[0] && !one_shot_select_i[0] && mode_field == `MODE_PERIOD
    |-> mode_0_o == OUT_PPG)
    else $error("output 0 not in PROGRAMMABLE_PERIOD_PULSE mode for mode code 11");

  // Counter-side sanity
  match_pulse_a: assert property ( // [R9]
    match_a_o |=> !match_a_o)
    else $error("compare A match pulse longer than one cycle");

  stop_count_a: assert property ( // [R9]
    !count_run_bit_i |=> count_o == `CNT_ZERO)
    else $error("counter not held at zero while stopped");

  // Main scenarios
  toggle_seen_c: cover property (chan[0].mode == OUT_TOGGLE && match_a_o ##[1:300] match_a_o);
  pwm_period_c: cover property (chan[0].mode == OUT_PWM && period_start ##[1:300] match_a_o);
  ppg_period_c: cover property (chan[0].mode == OUT_PPG && match_a_o ##[1:300] period_start);
  pwm_stop_c: cover property (chan[1].mode == OUT_PWM && $fell(count_run_bit_i));
endmodule : timer_output_waveform_control

// ==== verilog/up_counter.sv ====
`timescale 1ns/1ps
`include "timer_output_cfg.svh"
module up_counter (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  run_i,
  input  wire logic                  tick_i,
  input  wire logic                  clear_on_compare_reg_b_match_i,
  input  wire logic [`CNT_WIDTH-1:0] compare_reg_a_i,
  input  wire logic [`CNT_WIDTH-1:0] compare_reg_b_i,
  output logic      [`CNT_WIDTH-1:0] count_o,
  output logic                       match_a_o,
  output logic                       match_b_o,
  output logic                       period_start_o
);
  logic [`CNT_WIDTH-1:0] cnt_d;
  logic                  run_q;

  // Next count: zero while stopped, clear after reaching compare B if asked
  wire step    = run_i && tick_i;
  wire clr_hit = clear_on_compare_reg_b_match_i && (count_o == compare_reg_b_i);
  assign cnt_d = !run_i ? `CNT_ZERO :
                 !tick_i ? count_o :
                 clr_hit ? `CNT_ZERO : count_o + `CNT_ONE; // [R15]

  // Match and period pulses are registered, aligned with the new count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o        <= `CNT_ZERO;
      run_q          <= 1'b0;
      match_a_o      <= 1'b0;
      match_b_o      <= 1'b0;
      period_start_o <= 1'b0;
    end else begin
      count_o        <= cnt_d;
      run_q          <= run_i;
      match_a_o      <= step && (cnt_d == compare_reg_a_i);
      match_b_o      <= step && (cnt_d == compare_reg_b_i);
      period_start_o <= (run_i && !run_q) || (step && cnt_d == `CNT_ZERO); // [R18]
    end
  end

  clear_on_b_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    run_i && tick_i && clr_hit |=> count_o == `CNT_ZERO && period_start_o)
    else $error("counter not cleared after compare B match");
endmodule : up_counter
